// *** hdl/rsc_switch_config.sv ***
// Purpose: decodes the board switch bank and register parameters into settings
// Assumes: inputs synchronous to sys_clk; register writes come pre-decoded
// Notes: all outputs registered, one cycle behind the switches and two behind a parameter write
module rsc_switch_config
	import rsc_pkg::*;
#(
	parameter int NUM_OUT = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// switch banks
	input wire logic [7:0] addr_sw, // position 1 at bit 7
	input wire logic [7:0] mode_sw, // 1 standalone, 2 source, 3-5 time, 6 lift/dur
	input wire logic [3:0] cycle_sw, // cycle time code
	input wire logic [3:0] wait_sw, // wait time code
	input wire logic [2:0] type_sw, // device type code
	// parameter register writes from handheld_programmer or pc
	input wire logic prm_wr,
	input wire logic [4:0] wr_lift,
	input wire logic [6:0] wr_intensity,
	input wire logic [9:0] wr_freq,
	input wire logic [16:0] wr_duration,
	input wire logic [7:0] wr_over_amps,
	input wire logic [7:0] wr_under_amps,
	input wire logic [NUM_OUT-1:0] wr_out_en,
	input wire logic wr_relay_nc,
	// decoded configuration
	output logic cal_table,
	output logic standalone,
	output logic use_regs,
	output rsc_dev_t dev_type,
	output logic cfg_invalid,
	output logic [6:0] board_addr,
	output logic [10:0] first_output,
	output logic [12:0] init_wait_s,
	output logic [12:0] cycle_s,
	output logic [12:0] wait_s,
	// effective drive parameters
	output logic [4:0] lift_in,
	output logic [6:0] intensity,
	output logic [9:0] freq_cpm,
	output logic [16:0] duration_s,
	output logic continuous,
	output logic fire_all,
	output logic [3:0] times_in_seq,
	output logic [NUM_OUT-1:0] out_enable,
	output logic [7:0] over_amps,
	output logic [7:0] under_amps,
	output logic relay_nc
);
	// the address arithmetic serves sixteen outputs per board only, so refuse others
	if (NUM_OUT != RSC_OUT_PER_BOARD) begin : g_bad_num_out
		$error("NUM_OUT must match outputs per board");
	end

	// ------------------------------------------------------------
	// parameter registers
	// ------------------------------------------------------------
	logic [4:0] lift_q, lift_d;
	logic [6:0] int_q, int_d;
	logic [9:0] freq_q, freq_d;
	logic [16:0] dur_q, dur_d;
	logic [7:0] ovr_q, ovr_d, und_q, und_d;
	logic [NUM_OUT-1:0] en_q, en_d;
	logic nc_q, nc_d;

	// out-of-range writes are clamped so a bad entry can never overdrive a rapper
	always_comb begin
		lift_d = lift_q;
		int_d = int_q;
		freq_d = freq_q;
		dur_d = dur_q;
		ovr_d = ovr_q;
		und_d = und_q;
		en_d = en_q;
		nc_d = nc_q;
		if (prm_wr) begin
			lift_d = (wr_lift < RSC_LIFT_MIN) ? RSC_LIFT_MIN :
				(wr_lift > RSC_LIFT_MAX) ? RSC_LIFT_MAX : wr_lift;
			int_d = (wr_intensity < RSC_INT_MIN) ? RSC_INT_MIN :
				(wr_intensity > RSC_INT_FULL) ? RSC_INT_FULL : wr_intensity;
			freq_d = (wr_freq < RSC_FREQ_MIN) ? RSC_FREQ_MIN :
				(wr_freq > RSC_FREQ_MAX) ? RSC_FREQ_MAX : wr_freq;
			dur_d = (wr_duration < RSC_DUR_MIN) ? RSC_DUR_MIN :
				(wr_duration > RSC_DUR_MAX) ? RSC_DUR_MAX : wr_duration;
			ovr_d = wr_over_amps;
			und_d = wr_under_amps;
			en_d = wr_out_en;
			nc_d = wr_relay_nc;
		end
	end

	// registers only; reset values are the short switch defaults, with all output enables off
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lift_q <= RSC_LIFT_SHORT;
			int_q <= RSC_INT_FULL;
			freq_q <= RSC_FREQ_DEF;
			dur_q <= RSC_DUR_SHORT;
			ovr_q <= 8'h00;
			und_q <= 8'h00;
			en_q <= '0;
			nc_q <= 1'b0;
		end else begin
			lift_q <= lift_d;
			int_q <= int_d;
			freq_q <= freq_d;
			dur_q <= dur_d;
			ovr_q <= ovr_d;
			und_q <= und_d;
			en_q <= en_d;
			nc_q <= nc_d;
		end
	end

	// ------------------------------------------------------------
	// switch decode
	// ------------------------------------------------------------
	logic cal_d, sa_d, ur_d, inv_d, cont_d, fa_d;
	rsc_dev_t type_d;
	logic [6:0] addr_d;
	logic [10:0] first_d;
	logic [12:0] iw_d, cy_d, wt_d;
	logic [4:0] lift_o_d;
	logic [6:0] int_o_d;
	logic [9:0] freq_o_d;
	logic [16:0] dur_o_d;
	logic [3:0] times_d;
	logic [NUM_OUT-1:0] oe_d;
	logic [3:0] iw_code;
	logic impact;

	always_comb begin
		type_d = rsc_dev_t'(type_sw);
		inv_d = (type_d == RSC_INVALID);
		impact = (type_d == RSC_IMPACT_120) || (type_d == RSC_IMPACT_240);
		cal_d = impact & addr_sw[7];
		sa_d = mode_sw[7];
		ur_d = mode_sw[6];
		addr_d = {1'b0, addr_sw[5:0]} + RSC_ADDR_BASE;
		first_d = {5'h00, addr_sw[5:0]} * 11'(RSC_OUT_PER_BOARD) + 11'h001;
		iw_code = {1'b0, mode_sw[5:3]};
		iw_d = 13'(iw_code) * RSC_SEC_PER_STEP;
		cy_d = (cycle_sw == 4'h0) ? RSC_CYCLE_ZERO_S :
			13'(cycle_sw) * RSC_SEC_PER_STEP;
		wt_d = 13'(wait_sw) * RSC_SEC_PER_STEP;
		times_d = RSC_TIMES_ONCE;
		fa_d = 1'b0;
		if (ur_d) begin
			// register values serve both scheduled and stand-alone rapping
			lift_o_d = lift_q;
			int_o_d = int_q;
			freq_o_d = freq_q;
			dur_o_d = dur_q;
			oe_d = en_q;
		end else begin
			lift_o_d = mode_sw[2] ? RSC_LIFT_LONG : RSC_LIFT_SHORT;
			int_o_d = RSC_INT_FULL;
			freq_o_d = RSC_FREQ_DEF;
			oe_d = '1;
			if (type_d == RSC_MOTOR) begin
				dur_o_d = mode_sw[2] ? RSC_DUR_MAX : RSC_DUR_MOTOR;
				fa_d = mode_sw[2];
			end else begin
				dur_o_d = mode_sw[2] ? RSC_DUR_LONG : RSC_DUR_SHORT;
			end
		end
		cont_d = (dur_o_d == RSC_DUR_MAX);
		if (inv_d) begin
			oe_d = '0;
		end
	end

	// registers only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cal_table <= 1'b0;
			standalone <= 1'b0;
			use_regs <= 1'b0;
			dev_type <= RSC_INVALID;
			cfg_invalid <= 1'b1;
			board_addr <= RSC_ADDR_BASE;
			first_output <= 11'h001;
			init_wait_s <= 13'h0000;
			cycle_s <= RSC_CYCLE_ZERO_S;
			wait_s <= 13'h0000;
			lift_in <= RSC_LIFT_SHORT;
			intensity <= RSC_INT_FULL;
			freq_cpm <= RSC_FREQ_DEF;
			duration_s <= RSC_DUR_SHORT;
			continuous <= 1'b0;
			fire_all <= 1'b0;
			times_in_seq <= RSC_TIMES_ONCE;
			out_enable <= '0;
			over_amps <= 8'h00;
			under_amps <= 8'h00;
			relay_nc <= 1'b0;
		end else begin
			cal_table <= cal_d;
			standalone <= sa_d;
			use_regs <= ur_d;
			dev_type <= type_d;
			cfg_invalid <= inv_d;
			board_addr <= addr_d;
			first_output <= first_d;
			init_wait_s <= iw_d;
			cycle_s <= cy_d;
			wait_s <= wt_d;
			lift_in <= lift_o_d;
			intensity <= int_o_d;
			freq_cpm <= freq_o_d;
			duration_s <= dur_o_d;
			continuous <= cont_d;
			fire_all <= fa_d;
			times_in_seq <= times_d;
			out_enable <= oe_d;
			over_amps <= ovr_q;
			under_amps <= und_q;
			relay_nc <= nc_q;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_invalid_off: assert property (@(posedge sys_clk) disable iff (reset)
		cfg_invalid |-> out_enable == '0) else $error("outputs enabled with invalid type");
	a_cal_impact: assert property (@(posedge sys_clk) disable iff (reset)
		cal_table |-> (dev_type == RSC_IMPACT_120 || dev_type == RSC_IMPACT_240))
		else $error("calibration table on non-impact type");
	a_cal_select: assert property (@(posedge sys_clk) disable iff (reset)
		type_sw == 3'h0 |=> cal_table == $past(addr_sw[7])) else $error("lift table select wrong");
	a_cycle_zero: assert property (@(posedge sys_clk) disable iff (reset)
		cycle_sw == 4'h0 |=> cycle_s == RSC_CYCLE_ZERO_S) else $error("zero cycle not 16 s");
	a_wait_scale: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> wait_s == 13'($past(wait_sw)) * RSC_SEC_PER_STEP) else $error("wait scale wrong");
	a_addr_plus: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> board_addr == {1'b0, $past(addr_sw[5:0])} + 7'h01) else $error("address wrong");
	a_sa_full: assert property (@(posedge sys_clk) disable iff (reset)
		!mode_sw[6] |=> intensity == RSC_INT_FULL && freq_cpm == RSC_FREQ_DEF)
		else $error("stand-alone defaults wrong");
	a_lift_range: assert property (@(posedge sys_clk) disable iff (reset)
		lift_in >= RSC_LIFT_MIN && lift_in <= RSC_LIFT_MAX) else $error("lift out of range");
	a_freq_range: assert property (@(posedge sys_clk) disable iff (reset)
		use_regs |-> freq_cpm >= RSC_FREQ_MIN && freq_cpm <= RSC_FREQ_MAX)
		else $error("frequency out of range");
	// the stand-alone and source selections follow their switches one edge later
	a_standalone_sw: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> standalone == $past(mode_sw[7])) else $error("stand-alone select wrong");
	a_source_sw: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> use_regs == $past(mode_sw[6])) else $error("parameter source select wrong");
	// the type code passes unchanged, the unassigned code included
	a_type_pass: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> dev_type == rsc_dev_t'($past(type_sw))) else $error("device type wrong");
	// initial wait and non-zero cycle codes scale by five minutes
	a_init_scale: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> init_wait_s == 13'($past(mode_sw[5:3])) * RSC_SEC_PER_STEP)
		else $error("initial wait scale wrong");
	a_cycle_scale: assert property (@(posedge sys_clk) disable iff (reset)
		cycle_sw != 4'h0 |=> cycle_s == 13'($past(cycle_sw)) * RSC_SEC_PER_STEP)
		else $error("cycle scale wrong");
	// each board owns sixteen outputs starting right after the previous board
	a_first_out: assert property (@(posedge sys_clk) disable iff (reset)
		first_output == {board_addr - RSC_ADDR_BASE, 4'h0} + 11'h001)
		else $error("first output wrong");
	// switch-sourced lift follows the lift/duration switch
	a_lift_switch: assert property (@(posedge sys_clk) disable iff (reset)
		!mode_sw[6] |=> lift_in == ($past(mode_sw[2]) ? RSC_LIFT_LONG : RSC_LIFT_SHORT))
		else $error("switch lift wrong");
	// the long motor setting fires all outputs continuously
	a_motor_long: assert property (@(posedge sys_clk) disable iff (reset)
		!mode_sw[6] && mode_sw[2] && type_sw == RSC_MOTOR |=> fire_all && continuous)
		else $error("motor long setting wrong");
	// register intensity and every duration stay within their ranges
	a_int_range: assert property (@(posedge sys_clk) disable iff (reset)
		use_regs |-> intensity >= RSC_INT_MIN && intensity <= RSC_INT_FULL)
		else $error("intensity out of range");
	a_dur_range: assert property (@(posedge sys_clk) disable iff (reset)
		duration_s >= RSC_DUR_MIN && duration_s <= RSC_DUR_MAX)
		else $error("duration out of range");
	a_cont_max: assert property (@(posedge sys_clk) disable iff (reset)
		continuous == (duration_s == RSC_DUR_MAX)) else $error("continuous flag wrong");
	// a parameter write followed by the cycle in which the registers hold it
	sequence s_param_write;
		prm_wr ##1 1'b1;
	endsequence
	// an in-range intensity write while register sourcing stays selected
	sequence s_reg_load;
		prm_wr && mode_sw[6] && wr_intensity >= RSC_INT_MIN && wr_intensity <= RSC_INT_FULL
			##1 mode_sw[6];
	endsequence
	// a write after which register sourcing with a valid type is selected
	sequence s_en_load;
		prm_wr ##1 (mode_sw[6] && type_sw != RSC_INVALID);
	endsequence
	a_reg_source: assert property (@(posedge sys_clk) disable iff (reset)
		s_reg_load |=> intensity == $past(wr_intensity, 2))
		else $error("register value not used");
	// thresholds and relay polarity come from the registers two edges after a write
	a_amps_follow: assert property (@(posedge sys_clk) disable iff (reset)
		s_param_write |=> over_amps == $past(wr_over_amps, 2) &&
		under_amps == $past(wr_under_amps, 2) && relay_nc == $past(wr_relay_nc, 2))
		else $error("threshold or relay setting wrong");
	a_en_follow: assert property (@(posedge sys_clk) disable iff (reset)
		s_en_load |=> out_enable == $past(wr_out_en, 2)) else $error("output enables wrong");
endmodule : rsc_switch_config

// *** inc/rsc_pkg.sv ***
// Purpose: constants and types for the rapper driver switch configuration decoder
// Assumes: switch banks are static levels, synchronous to sys_clk
// Notes: times are in seconds, lift in inches, intensity in percent
package rsc_pkg;
	// ------------------------------------------------------------
	// device types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RSC_IMPACT_120 = 3'h0,
		RSC_AC_VIB = 3'h1,
		RSC_MOTOR = 3'h2,
		RSC_MULTI = 3'h3,
		RSC_DC_VIB = 3'h4,
		RSC_POR_OUT = 3'h5,
		RSC_IMPACT_240 = 3'h6,
		RSC_INVALID = 3'h7
	} rsc_dev_t;
	// ------------------------------------------------------------
	// decoding constants
	// ------------------------------------------------------------
	localparam logic [12:0] RSC_SEC_PER_STEP = 13'h012c; // five minutes
	localparam logic [12:0] RSC_CYCLE_ZERO_S = 13'h0010; // sixteen seconds
	localparam logic [4:0] RSC_LIFT_SHORT = 5'h04;
	localparam logic [4:0] RSC_LIFT_LONG = 5'h08;
	localparam logic [4:0] RSC_LIFT_MIN = 5'h01;
	localparam logic [4:0] RSC_LIFT_MAX = 5'h10;
	localparam logic [6:0] RSC_INT_MIN = 7'h05;
	localparam logic [6:0] RSC_INT_FULL = 7'h64;
	localparam logic [9:0] RSC_FREQ_MIN = 10'h0c8;
	localparam logic [9:0] RSC_FREQ_MAX = 10'h258;
	localparam logic [9:0] RSC_FREQ_DEF = 10'h12c;
	localparam logic [16:0] RSC_DUR_SHORT = 17'h00002; // vibrator/multi, seconds
	localparam logic [16:0] RSC_DUR_LONG = 17'h00004;
	localparam logic [16:0] RSC_DUR_MOTOR = 17'h0012c; // five minutes
	localparam logic [16:0] RSC_DUR_MIN = 17'h00001;
	localparam logic [16:0] RSC_DUR_MAX = 17'h1517f; // 23:59:59, continuous
	localparam logic [3:0] RSC_TIMES_ONCE = 4'h1;
	localparam logic [6:0] RSC_ADDR_BASE = 7'h01;
	localparam int RSC_OUT_PER_BOARD = 16;
endpackage : rsc_pkg

// *** tb/rsc_prog_model.sv ***
// Purpose: behavioural handheld_programmer that loads the parameter registers
// Assumes: the decoder samples the write strobe on the rising edge
// Notes: released data lines carry the inverse of the last value, never a stale copy
module rsc_prog_model (
	// clock
	input wire logic sys_clk,
	// parameter write
	output logic prm_wr,
	output logic [4:0] wr_lift,
	output logic [6:0] wr_intensity,
	output logic [9:0] wr_freq,
	output logic [16:0] wr_duration,
	output logic [7:0] wr_over_amps,
	output logic [7:0] wr_under_amps,
	output logic [15:0] wr_out_en,
	output logic wr_relay_nc
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------
	// idle at time zero
	// ----------------------------------------------------------
	initial begin
		prm_wr = 1'b0;
		{wr_lift, wr_intensity, wr_freq, wr_duration} = '0;
		{wr_over_amps, wr_under_amps, wr_out_en, wr_relay_nc} = '0;
	end
	// one strobe cycle carries every parameter at once
	task load(input logic [4:0] l, input logic [6:0] i, input logic [9:0] f,
			input logic [16:0] d, input logic [7:0] o, input logic [7:0] u,
			input logic [15:0] e, input logic n);
		@(negedge sys_clk);
		prm_wr = 1'b1;
		{wr_lift, wr_intensity, wr_freq, wr_duration} = {l, i, f, d};
		{wr_over_amps, wr_under_amps, wr_out_en, wr_relay_nc} = {o, u, e, n};
		@(negedge sys_clk);
		// released: flip the data so a late sample shows up
		prm_wr = 1'b0;
		{wr_lift, wr_intensity, wr_freq, wr_duration} = ~{l, i, f, d};
		{wr_over_amps, wr_under_amps, wr_out_en, wr_relay_nc} = ~{o, u, e, n};
	endtask : load
endmodule : rsc_prog_model

// *** tb/rapper_module_switch_config_test.sv ***
// Purpose: self-checking bench for the switch configuration decoder
// Assumes: inputs change on the falling edge, outputs settle one edge later
// Notes: register loads come from the programmer model
module rapper_module_switch_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	import rsc_pkg::*;
	// ----------------------------------------------------------
	// signals
	// ----------------------------------------------------------
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr_sw = 8'h00, mode_sw = 8'h00;
	logic [3:0] cycle_sw = 4'h0, wait_sw = 4'h0;
	logic [2:0] type_sw = 3'h0;
	logic prm_wr, wr_relay_nc, cal_table, standalone, use_regs, cfg_invalid;
	logic continuous, fire_all, relay_nc;
	logic [4:0] wr_lift, lift_in;
	logic [6:0] wr_intensity, intensity, board_addr;
	logic [9:0] wr_freq, freq_cpm;
	logic [16:0] wr_duration, duration_s;
	logic [7:0] wr_over_amps, wr_under_amps, over_amps, under_amps;
	logic [15:0] wr_out_en, out_enable;
	logic [10:0] first_output;
	logic [12:0] init_wait_s, cycle_s, wait_s;
	logic [3:0] times_in_seq;
	rsc_dev_t dev_type;
	int mismatches = 0;
	int check_count = 0;
	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;
	// ----------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------
	rsc_switch_config #(.NUM_OUT(16)) rsc_switch_config_inst (.sys_clk, .reset, .addr_sw,
		.mode_sw, .cycle_sw, .wait_sw, .type_sw, .prm_wr, .wr_lift, .wr_intensity,
		.wr_freq, .wr_duration, .wr_over_amps, .wr_under_amps, .wr_out_en, .wr_relay_nc,
		.cal_table, .standalone, .use_regs, .dev_type, .cfg_invalid, .board_addr,
		.first_output, .init_wait_s, .cycle_s, .wait_s, .lift_in, .intensity, .freq_cpm,
		.duration_s, .continuous, .fire_all, .times_in_seq, .out_enable, .over_amps,
		.under_amps, .relay_nc);
	rsc_prog_model rsc_prog_model_inst (.sys_clk, .prm_wr, .wr_lift, .wr_intensity,
		.wr_freq, .wr_duration, .wr_over_amps, .wr_under_amps, .wr_out_en, .wr_relay_nc);
	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// switch bank change, then wait until the registered outputs follow
	task sw(input logic [7:0] a, input logic [7:0] m, input logic [3:0] c,
			input logic [3:0] w, input logic [2:0] t);
		@(negedge sys_clk);
		{addr_sw, mode_sw, cycle_sw, wait_sw, type_sw} = {a, m, c, w, t};
		repeat (2) @(negedge sys_clk);
	endtask : sw
	// load registers, then check clamped values two edges later
	task regchk(input logic [4:0] l, input logic [6:0] i, input logic [9:0] f,
			input logic [16:0] d, input int el, input int ei, input int ef, input int ed);
		rsc_prog_model_inst.load(l, i, f, d, 8'h5a, 8'h21, 16'h00f3, 1'b1);
		repeat (2) @(negedge sys_clk);
		chk(lift_in, el);
		chk(intensity, ei);
		chk(freq_cpm, ef);
		chk(duration_s, ed);
		chk(continuous, ed == 32'(RSC_DUR_MAX));
		chk(over_amps, 8'h5a);
		chk(under_amps, 8'h21);
		chk(out_enable, 16'h00f3);
		chk(relay_nc, 1'b1);
	endtask : regchk
	task results;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	// watchdog: the sequence needs about 124 cycles, the limit is 2000
	initial begin
		#40000;
		mismatches++;
		results();
	end
	// ----------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------
	initial begin
		repeat (4) @(negedge sys_clk);
		chk(cfg_invalid, 1);
		chk(out_enable, 0);
		chk(board_addr, 1);
		reset = 1'b0;
		// every type code; the installer always sets them before use
		for (int i = 0; i < 8; i++) begin
			sw(8'h00, 8'h80, 4'h1, 4'h1, 3'(i));
			chk(dev_type, i);
			chk(cfg_invalid, i == 7);
			chk(out_enable, (i == 7) ? 0 : 16'hffff);
			chk(standalone, 1);
		end
		sw(8'h80, 8'h00, 4'h1, 4'h1, 3'h0);
		chk(cal_table, 1);
		chk({standalone, use_regs}, 0);
		sw(8'h80, 8'h00, 4'h1, 4'h1, 3'h1);
		chk(cal_table, 0);
		sw(8'h3f, 8'h00, 4'h1, 4'h1, 3'h0);
		chk(cal_table, 0);
		chk({board_addr, first_output}, {7'd64, 11'd1009});
		sw(8'h05, 8'h00, 4'h1, 4'h1, 3'h0);
		chk({board_addr, first_output}, {7'd6, 11'd81});
		// every time code, with the zero cycle case
		for (int i = 0; i < 16; i++) begin
			sw(8'h00, {2'b00, 3'(i % 8), 3'b000}, 4'(i), 4'(15 - i), 3'h0);
			chk(cycle_s, (i == 0) ? 16 : i * 300);
			chk(wait_s, (15 - i) * 300);
			chk(init_wait_s, (i % 8) * 300);
		end
		// lift/duration switch per kind of device
		for (int s = 0; s < 2; s++) begin
			sw(8'h00, {5'h10, 1'(s), 2'b00}, 4'h1, 4'h1, 3'h0);
			chk(lift_in, s ? 8 : 4);
			chk(times_in_seq, 1);
			sw(8'h00, {5'h10, 1'(s), 2'b00}, 4'h1, 4'h1, 3'h3);
			chk(duration_s, s ? 4 : 2);
			chk({intensity, freq_cpm}, {7'd100, 10'd300});
			sw(8'h00, {5'h10, 1'(s), 2'b00}, 4'h1, 4'h1, 3'h2);
			chk({fire_all, continuous}, {1'(s), 1'(s)});
			if (s == 0)
				chk(duration_s, 300);
		end
		// register sourcing, scheduled then stand-alone
		sw(8'h00, 8'h40, 4'h1, 4'h1, 3'h3);
		chk(use_regs, 1);
		regchk(5'd20, 7'd3, 10'd100, 17'd0, 16, 5, 200, 1);
		sw(8'h00, 8'hc0, 4'h1, 4'h1, 3'h3);
		regchk(5'd0, 7'd101, 10'd700, RSC_DUR_MAX, 1, 100, 600, 32'(RSC_DUR_MAX));
		regchk(5'd9, 7'd50, 10'd450, 17'd61, 9, 50, 450, 61);
		results();
	end
endmodule : rapper_module_switch_config_test
